// >>> core/dprs_pkg.sv
package dprs_pkg;
   // port count and bus widths
   localparam int NUM_DS    = 3;
   localparam int AW        = 8;
   localparam int DW        = 32;
   localparam int DLY_W     = 8;
   localparam int MIN_W     = 16;
   localparam int PRE_W     = 8;

   // clock and timing, times in their printed unit
   localparam int CLK_PERIOD_NS  = 8;
   localparam int MIN_RST_US     = 200;
   localparam int DLY_UNIT_NS    = 1000;
   localparam int MIN_RST_CYCLES = (MIN_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DLY_TICK_CYCLES = (DLY_UNIT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                    DLY_UNIT_NS / CLK_PERIOD_NS;

   // register groups: address bits [7:4], port index in bits [3:2]
   localparam logic [3:0] GRP_US_BRIDGE = 4'h0;
   localparam logic [3:0] GRP_DS_BRIDGE = 4'h1;
   localparam logic [3:0] GRP_HP_CFG    = 4'h2;
   localparam logic [3:0] GRP_SLOT_CTL  = 4'h3;
   localparam logic [3:0] GRP_STATUS    = 4'h4;

   // bridge_control field
   localparam int SBR_BIT = 6;
   // hotplug_config_control fields
   localparam int HP_MODE_LSB = 0;
   localparam int HP_GPIO_BIT = 2;
   localparam int HP_P2R_LSB  = 8;
   localparam int HP_R2P_LSB  = 16;
   // slot_control field
   localparam int PWR_OFF_BIT = 10;
   // status layout, one byte per port
   localparam int ST_STRIDE  = 8;
   localparam int ST_RSTN    = 0;
   localparam int ST_PWREN   = 1;
   localparam int ST_INRST   = 2;
   localparam int ST_PGOOD   = 3;

   // reset values
   localparam logic [DLY_W-1:0] P2R_INIT  = 8'h0A;
   localparam logic [DLY_W-1:0] R2P_INIT  = 8'h0A;
   localparam logic             PWR_OFF_INIT = 1'b1;

   typedef enum logic [1:0] {
      MODE_PWR_EN    = 2'b00,
      MODE_PWR_GOOD  = 2'b01,
      MODE_HOT_RESET = 2'b10
   } dprs_mode_t;

   typedef enum logic [2:0] {
      ST_ASSERT  = 3'b000,
      ST_PG_WAIT = 3'b001,
      ST_P2R     = 3'b010,
      ST_RUN     = 3'b011,
      ST_R2P     = 3'b100
   } dprs_state_t;
endpackage

// >>> core/dprs_core.sv
`timescale 1ns/1ps
module dprs_core
   import dprs_pkg::*;
#(
   parameter int MIN_RST_CYC = MIN_RST_CYCLES
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic [AW-1:0]     reg_addr,
   input  wire logic [DW-1:0]     reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DW-1:0]     reg_rdata,
   input  wire logic              hot_reset_in,
   input  wire logic [NUM_DS-1:0] link_up,
   input  wire logic [NUM_DS-1:0] slot_power_good_n,
   output logic      [NUM_DS-1:0] port_reset_out_n,
   output logic      [NUM_DS-1:0] port_reset_oe,
   output logic      [NUM_DS-1:0] slot_power_enable_out,
   output logic      [NUM_DS-1:0] ts1_hot_reset,
   output logic      [NUM_DS-1:0] tlp_flush,
   output logic      [NUM_DS-1:0] port_logic_reset,
   output logic      [NUM_DS-1:0] ds_sec_unsupported,
   output logic                   us_sec_unsupported
);

   localparam logic [MIN_W-1:0] MIN_LOAD = MIN_W'(MIN_RST_CYC - 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(DLY_TICK_CYCLES - 1);

   logic                us_sbr_reg;
   logic [NUM_DS-1:0]   ds_sbr_reg;
   dprs_mode_t          mode_reg  [NUM_DS];
   logic [NUM_DS-1:0]   gpio_en_reg;
   logic [DLY_W-1:0]    p2r_reg   [NUM_DS];
   logic [DLY_W-1:0]    r2p_reg   [NUM_DS];
   logic [NUM_DS-1:0]   pwr_off_reg;
   dprs_state_t         st_reg    [NUM_DS];
   logic [DLY_W-1:0]    dly_reg   [NUM_DS];
   logic [MIN_W-1:0]    min_reg   [NUM_DS];
   logic [PRE_W-1:0]    pre_reg;
   logic                tick;
   logic [NUM_DS-1:0]   rst_n_reg;
   logic [NUM_DS-1:0]   pe_reg;
   logic [NUM_DS-1:0]   pg_meta_reg;
   logic [NUM_DS-1:0]   pg_n_reg;
   logic [NUM_DS-1:0]   in_rst;
   logic [NUM_DS-1:0]   in_rst_d_reg;
   logic [NUM_DS-1:0]   hr_trig;
   logic [NUM_DS-1:0]   min_done;
   logic [NUM_DS-1:0]   ts1_reg;
   logic [NUM_DS-1:0]   flush_reg;
   logic [NUM_DS-1:0]   ur_ds_reg;
   logic                ur_us_reg;
   logic [DW-1:0]       rdata_reg;
   logic [DW-1:0]       rdata_next;

   // port index of a per-port register, valid only below NUM_DS
   function automatic int port_of(input logic [AW-1:0] a);
      return int'(a[3:2]);
   endfunction

   function automatic logic port_ok(input logic [AW-1:0] a);
      return (port_of(a) < NUM_DS) && (a[1:0] == 2'b00);
   endfunction

   // a port is in secondary bus reset from either bridge
   always_comb begin
      for (int i = 0; i < NUM_DS; i++) begin
         in_rst[i]   = us_sbr_reg | ds_sbr_reg[i];
         hr_trig[i]  = hot_reset_in | in_rst[i];
         min_done[i] = (min_reg[i] == '0);
      end
   end

   // power-good pins come from outside, two flops before use
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pg_meta_reg <= '1;
         pg_n_reg    <= '1;
      end else begin
         pg_meta_reg <= slot_power_good_n;
         pg_n_reg    <= pg_meta_reg;
      end
   end

   // upstream bridge control, written at any time
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         us_sbr_reg <= 1'b0;
      end else if (reg_wr && reg_addr[7:4] == GRP_US_BRIDGE && reg_addr[3:0] == 4'h0) begin
         us_sbr_reg <= reg_wdata[SBR_BIT];
      end
   end

   // downstream bridge and slot control registers return to init during upstream reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ds_sbr_reg  <= '0;
         pwr_off_reg <= {NUM_DS{PWR_OFF_INIT}};
      end else if (us_sbr_reg) begin
         ds_sbr_reg  <= '0;
         pwr_off_reg <= {NUM_DS{PWR_OFF_INIT}};
      end else if (reg_wr && port_ok(reg_addr)) begin
         if (reg_addr[7:4] == GRP_DS_BRIDGE) begin
            ds_sbr_reg[port_of(reg_addr)] <= reg_wdata[SBR_BIT];
         end else if (reg_addr[7:4] == GRP_SLOT_CTL) begin
            pwr_off_reg[port_of(reg_addr)] <= reg_wdata[PWR_OFF_BIT];
         end
      end
   end

   // unlock-writable config survives secondary bus resets
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_DS; i++) begin
            mode_reg[i] <= MODE_PWR_EN;
            p2r_reg[i]  <= P2R_INIT;
            r2p_reg[i]  <= R2P_INIT;
         end
         gpio_en_reg <= '0;
      end else if (reg_wr && port_ok(reg_addr) && reg_addr[7:4] == GRP_HP_CFG) begin
         mode_reg[port_of(reg_addr)]    <= dprs_mode_t'(reg_wdata[HP_MODE_LSB +: 2]);
         gpio_en_reg[port_of(reg_addr)] <= reg_wdata[HP_GPIO_BIT];
         p2r_reg[port_of(reg_addr)]     <= reg_wdata[HP_P2R_LSB +: DLY_W];
         r2p_reg[port_of(reg_addr)]     <= reg_wdata[HP_R2P_LSB +: DLY_W];
      end
   end

   // read mux; config reads answer even while ports are in reset
   always_comb begin
      rdata_next = '0;
      if (reg_addr[7:4] == GRP_US_BRIDGE && reg_addr[3:0] == 4'h0) begin
         rdata_next[SBR_BIT] = us_sbr_reg;
      end else if (reg_addr[7:4] == GRP_STATUS && reg_addr[3:0] == 4'h0) begin
         for (int i = 0; i < NUM_DS; i++) begin
            rdata_next[i*ST_STRIDE + ST_RSTN]  = rst_n_reg[i];
            rdata_next[i*ST_STRIDE + ST_PWREN] = pe_reg[i];
            rdata_next[i*ST_STRIDE + ST_INRST] = in_rst[i];
            rdata_next[i*ST_STRIDE + ST_PGOOD] = ~pg_n_reg[i];
         end
      end else if (!port_ok(reg_addr)) begin
         rdata_next = '0;
      end else if (reg_addr[7:4] == GRP_DS_BRIDGE) begin
         rdata_next[SBR_BIT] = ds_sbr_reg[port_of(reg_addr)];
      end else if (reg_addr[7:4] == GRP_HP_CFG) begin
         rdata_next[HP_MODE_LSB +: 2]     = mode_reg[port_of(reg_addr)];
         rdata_next[HP_GPIO_BIT]          = gpio_en_reg[port_of(reg_addr)];
         rdata_next[HP_P2R_LSB +: DLY_W]  = p2r_reg[port_of(reg_addr)];
         rdata_next[HP_R2P_LSB +: DLY_W]  = r2p_reg[port_of(reg_addr)];
      end else if (reg_addr[7:4] == GRP_SLOT_CTL) begin
         rdata_next[PWR_OFF_BIT] = pwr_off_reg[port_of(reg_addr)];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= reg_rd ? rdata_next : '0;
      end
   end

   // secondary reset side effects toward stacks and queues
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         in_rst_d_reg <= '0;
         ts1_reg      <= '0;
         flush_reg    <= '0;
         ur_ds_reg    <= '0;
         ur_us_reg    <= 1'b0;
      end else begin
         in_rst_d_reg <= in_rst;
         ts1_reg      <= in_rst & link_up;
         flush_reg    <= in_rst & ~in_rst_d_reg;
         ur_ds_reg    <= in_rst;
         ur_us_reg    <= us_sbr_reg;
      end
   end

   // shared prescaler makes the delay unit; one divider saves area
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= tick ? '0 : pre_reg + 8'h01;
      end
   end
   assign tick = (pre_reg == PRE_LAST);

   // minimum assertion width, reloaded while the output is negated
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_DS; i++) begin
            min_reg[i] <= MIN_LOAD;
         end
      end else begin
         for (int i = 0; i < NUM_DS; i++) begin
            if (rst_n_reg[i]) begin
               min_reg[i] <= MIN_LOAD;
            end else if (!min_done[i]) begin
               min_reg[i] <= min_reg[i] - 16'h0001;
            end
         end
      end
   end

   // per-port reset output sequencer
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_DS; i++) begin
            st_reg[i]  <= ST_ASSERT;
            dly_reg[i] <= '0;
         end
         rst_n_reg <= '0;
         pe_reg    <= '0;
      end else begin
         for (int i = 0; i < NUM_DS; i++) begin
            if (tick && dly_reg[i] != '0) begin
               dly_reg[i] <= dly_reg[i] - 8'h01;
            end
            if (mode_reg[i] == MODE_HOT_RESET) begin
               pe_reg[i] <= ~pwr_off_reg[i];
               if (hr_trig[i]) begin
                  st_reg[i]    <= ST_ASSERT;
                  rst_n_reg[i] <= 1'b0;
               end else if (min_done[i]) begin
                  st_reg[i]    <= ST_RUN;
                  rst_n_reg[i] <= 1'b1;
               end
            end else begin
               case (st_reg[i])
                  ST_ASSERT: begin
                     rst_n_reg[i] <= 1'b0;
                     if (!pwr_off_reg[i]) begin
                        pe_reg[i] <= 1'b1;
                        if (mode_reg[i] == MODE_PWR_GOOD) begin
                           st_reg[i] <= ST_PG_WAIT;
                        end else begin
                           st_reg[i]  <= ST_P2R;
                           dly_reg[i] <= p2r_reg[i];
                        end
                     end
                  end
                  ST_PG_WAIT: begin
                     if (pwr_off_reg[i]) begin
                        st_reg[i]  <= ST_R2P;
                        dly_reg[i] <= r2p_reg[i];
                     end else if (!pg_n_reg[i]) begin
                        st_reg[i]  <= ST_P2R;
                        dly_reg[i] <= p2r_reg[i];
                     end
                  end
                  ST_P2R: begin
                     if (pwr_off_reg[i]) begin
                        st_reg[i]  <= ST_R2P;
                        dly_reg[i] <= r2p_reg[i];
                     end else if (mode_reg[i] == MODE_PWR_GOOD && pg_n_reg[i]) begin
                        st_reg[i] <= ST_PG_WAIT;
                     end else if (dly_reg[i] == '0 && min_done[i]) begin
                        st_reg[i]    <= ST_RUN;
                        rst_n_reg[i] <= 1'b1;
                     end
                  end
                  ST_RUN: begin
                     if (pwr_off_reg[i]) begin
                        st_reg[i]    <= ST_R2P;
                        rst_n_reg[i] <= 1'b0;
                        dly_reg[i]   <= r2p_reg[i];
                     end else if (mode_reg[i] == MODE_PWR_GOOD && pg_n_reg[i]) begin
                        st_reg[i]    <= ST_ASSERT;
                        rst_n_reg[i] <= 1'b0;
                     end else begin
                        rst_n_reg[i] <= 1'b1;
                     end
                  end
                  ST_R2P: begin
                     rst_n_reg[i] <= 1'b0;
                     if (dly_reg[i] == '0) begin
                        pe_reg[i] <= 1'b0;
                        st_reg[i] <= ST_ASSERT;
                     end
                  end
                  default: begin
                     st_reg[i]    <= ST_ASSERT;
                     rst_n_reg[i] <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   // pins float until software selects the reset function
   assign port_reset_out_n      = rst_n_reg;
   assign port_reset_oe         = gpio_en_reg;
   assign slot_power_enable_out = pe_reg;
   assign ts1_hot_reset         = ts1_reg;
   assign tlp_flush             = flush_reg;
   assign port_logic_reset      = in_rst_d_reg;
   assign ds_sec_unsupported    = ur_ds_reg;
   assign us_sec_unsupported    = ur_us_reg;
   assign reg_rdata             = rdata_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_release(int p);
      !rst_n_reg[p] ##1 rst_n_reg[p];
   endsequence

   a_us_unsupported: assert property (us_sbr_reg |=> us_sec_unsupported)
      else $error("upstream secondary TLPs not marked unsupported");

   a_us_read_back: assert property (reg_rd && reg_addr == 8'h00 |=>
                                    reg_rdata[SBR_BIT] == $past(us_sbr_reg))
      else $error("upstream bridge read wrong");

   for (genvar g = 0; g < NUM_DS; g++) begin : g_chk
      logic [MIN_W-1:0] low_len_reg;
      // counts cycles of the current reset assertion, saturating
      always_ff @(posedge mclk or negedge nrst) begin
         if (!nrst) begin
            low_len_reg <= '0;
         end else if (rst_n_reg[g]) begin
            low_len_reg <= '0;
         end else if (low_len_reg != '1) begin
            low_len_reg <= low_len_reg + 16'h0001;
         end
      end

      a_ts1_on_reset: assert property (in_rst[g] && link_up[g] |=> ts1_hot_reset[g])
         else $error("hot reset TS1 not requested");
      a_flush_on_entry: assert property ($rose(in_rst[g]) |=> tlp_flush[g] ##1 !tlp_flush[g])
         else $error("queue flush pulse missing");
      // release cycle still samples the full count, clearing lands one edge later
      a_min_width: assert property (s_release(g) |-> low_len_reg >= MIN_RST_CYC)
         else $error("reset pulse shorter than minimum");
      a_pe_power_off: assert property (mode_reg[g] == MODE_PWR_EN && pwr_off_reg[g] &&
                                       $past(pwr_off_reg[g]) |-> !port_reset_out_n[g])
         else $error("reset negated while slot power off");
      a_pg_release: assert property ((mode_reg[g] == MODE_PWR_GOOD) and s_release(g) |->
                                     !$past(pg_n_reg[g]))
         else $error("reset released without power good");
      a_pg_loss: assert property (mode_reg[g] == MODE_PWR_GOOD && rst_n_reg[g] &&
                                  pg_n_reg[g] |=> !rst_n_reg[g])
         else $error("power loss did not assert reset");
      a_hr_assert: assert property (mode_reg[g] == MODE_HOT_RESET && hr_trig[g] |=>
                                    !port_reset_out_n[g])
         else $error("hot reset source did not assert reset");
      a_enable_order: assert property ($fell(pe_reg[g]) && mode_reg[g] != MODE_HOT_RESET |->
                                       !rst_n_reg[g] && $past(!rst_n_reg[g]))
         else $error("power enable dropped before reset asserted");
   end

endmodule

// >>> verification/dprs_slot_model.sv
`timescale 1ns/1ps
module dprs_slot_model
   import dprs_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic [NUM_DS-1:0] power_en,
   input  wire logic [NUM_DS-1:0] fault,
   input  wire logic [NUM_DS-1:0] slow,
   input  wire logic [NUM_DS-1:0] rst_n,
   input  wire logic [NUM_DS-1:0] rst_oe,
   output logic      [NUM_DS-1:0] power_good_n,
   output logic      [NUM_DS-1:0] rst_pin
);
   int ramp [NUM_DS];

   // supply ramps after enable; a slow slot makes the sequencer wait on good
   always_ff @(posedge mclk or negedge nrst) begin
      for (int i = 0; i < NUM_DS; i++) begin
         if (!nrst || !power_en[i] || fault[i]) begin
            ramp[i]         <= 0;
            power_good_n[i] <= 1'b1;
         end else begin
            ramp[i] <= ramp[i] + 1;
            if (ramp[i] >= (slow[i] ? 40 : 4)) begin
               power_good_n[i] <= 1'b0;
            end
         end
      end
   end

   // undriven reset pins fall to the board pull-down
   always_comb rst_pin = rst_n & rst_oe;
endmodule

// >>> verification/tb_dprs_core.sv
`timescale 1ns/1ps
module tb_dprs_core
   import dprs_pkg::*;
();
   localparam int MRC = 20;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} dprs_row_t;
   logic              mclk;
   logic              nrst;
   logic [AW-1:0]     reg_addr;
   logic [DW-1:0]     reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DW-1:0]     reg_rdata;
   logic              hot_reset_in;
   logic              us_ur;
   logic [NUM_DS-1:0] link_up, pg_n, rst_n, rst_oe, pe, ts1, flush, plr, ds_ur;
   logic [NUM_DS-1:0] fault, slow, pin;
   int                mismatches, check_count, n;
   // reset values, refused places, then per-port mode setup
   dprs_row_t         rows [10] = '{
      '{8'h00, 1'b0, 32'h0, 32'h0}, '{8'h10, 1'b0, 32'h0, 32'h0},
      '{8'h24, 1'b0, 32'h0, 32'h000A0A00}, '{8'h38, 1'b0, 32'h0, 32'h00000400},
      '{8'h40, 1'b0, 32'h0, 32'h0}, '{8'h1C, 1'b1, 32'hFFFFFFFF, 32'h0},
      '{8'h50, 1'b1, 32'hFFFFFFFF, 32'h0}, '{8'h20, 1'b1, 32'h00020004, 32'h00020004},
      '{8'h24, 1'b1, 32'h00000205, 32'h00000205}, '{8'h28, 1'b1, 32'h6, 32'h6}};

   dprs_core #(.MIN_RST_CYC(MRC)) i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .hot_reset_in(hot_reset_in), .link_up(link_up), .slot_power_good_n(pg_n),
      .port_reset_out_n(rst_n), .port_reset_oe(rst_oe), .slot_power_enable_out(pe),
      .ts1_hot_reset(ts1), .tlp_flush(flush), .port_logic_reset(plr),
      .ds_sec_unsupported(ds_ur), .us_sec_unsupported(us_ur));
   dprs_slot_model i_slot (.mclk(mclk), .nrst(nrst), .power_en(pe), .fault(fault),
      .slow(slow), .rst_n(rst_n), .rst_oe(rst_oe), .power_good_n(pg_n), .rst_pin(pin));

   // free-running core clock
   always #4 mclk = ~mclk;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_ge(input string nm, input int lo, input int got);
      check_count++;
      if (got < lo) begin
         mismatches++;
         $display("Error %s expected at least %0d seen %0d", nm, lo, got);
      end
   endtask
   // step past the edge so registered outputs have settled
   task automatic tick(input int k);
      repeat (k) begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask
   function automatic logic sig(input int s, input int p);
      case (s)
         0: return rst_n[p];
         1: return pe[p];
         default: return pg_n[p];
      endcase
   endfunction
   // cycles until an output reaches a level; bounded so a stuck port cannot hang
   task automatic wait_for(input int s, input int p, input logic v, output int c);
      c = 0;
      while (sig(s, p) !== v && c < 3000) begin
         tick(1);
         c++;
      end
      chk("wait bound", 32'h1, 32'(c < 3000));
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog: the sequence needs a few thousand cycles at most
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      results();
   end

   initial begin
      mclk         = 1'b0;
      nrst         = 1'b0;
      reg_addr     = '0;
      reg_wdata    = '0;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      hot_reset_in = 1'b0;
      link_up      = 3'b101;
      fault        = '0;
      slow         = 3'b010;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      tick(1);
      chk("outputs after reset", 32'h0, {23'h0, rst_n, rst_oe, pe});
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr(rows[i].a, rows[i].d);
         end
         rd(rows[i].a, rows[i].e);
      end
      chk("pin enables", 32'h7, {29'h0, rst_oe});
      chk("pins while off", 32'h0, {30'h0, pin[1:0]});
      // power-enable mode on port 0
      wr(8'h30, 32'h0);
      wait_for(1, 0, 1'b1, n);
      chk("reset at enable", 32'h0, {31'h0, rst_n[0]});
      wait_for(0, 0, 1'b1, n);
      tick(50);
      chk("reset while on", 32'h1, {31'h0, pin[0]});
      wr(8'h30, 32'h400);
      tick(2);
      chk("reset first", 32'h2, {30'h0, pe[0], rst_n[0]});
      wait_for(1, 0, 1'b0, n);
      chk_ge("reset to power", 100, n);
      // power-good mode on port 1 with a slow supply, then a fault
      wr(8'h34, 32'h0);
      wait_for(2, 1, 1'b0, n);
      chk("reset before good", 32'h0, {31'h0, rst_n[1]});
      wait_for(0, 1, 1'b1, n);
      chk_ge("good to release", 100, n);
      tick(20);
      fault[1] = 1'b1;
      wait_for(0, 1, 1'b0, n);
      chk("fault reaction", 32'h1, 32'(n <= 6));
      fault[1] = 1'b0;
      // hot-reset mode on port 2: short and long triggers
      wait_for(0, 2, 1'b1, n);
      @(posedge mclk);
      hot_reset_in <= 1'b1;
      @(posedge mclk);
      hot_reset_in <= 1'b0;
      #1;
      wait_for(0, 2, 1'b0, n);
      chk("hot assert", 32'h1, 32'(n <= 2));
      wait_for(0, 2, 1'b1, n);
      chk_ge("short trigger hold", MRC - 2, n);
      @(posedge mclk);
      hot_reset_in <= 1'b1;
      tick(60);
      chk("long trigger", 32'h0, {31'h0, rst_n[2]});
      @(posedge mclk);
      hot_reset_in <= 1'b0;
      #1;
      wait_for(0, 2, 1'b1, n);
      // minimum already served, so release must follow the trigger at once
      chk("release after trigger", 32'h1, 32'(n <= 2));
      // downstream bus reset on port 2
      wr(8'h18, 32'h40);
      tick(1);
      chk("ds reset start", 32'h924, {20'h0, ts1, flush, plr, ds_ur});
      tick(1);
      chk("ds reset held", 32'h824, {20'h0, ts1, flush, plr, ds_ur});
      chk("ds reset pin", 32'h0, {31'h0, rst_n[2]});
      rd(8'h18, 32'h40);
      wr(8'h18, 32'h0);
      tick(1);
      chk("ds reset end", 32'h0, {20'h0, ts1, flush, plr, ds_ur});
      // upstream bus reset
      wr(8'h00, 32'h40);
      tick(1);
      chk("us reset start", {22'h0, 10'b1_101_111_111}, {22'h0, us_ur, ts1, flush, plr});
      wr(8'h10, 32'h40);
      rd(8'h10, 32'h0);
      rd(8'h00, 32'h40);
      rd(8'h34, 32'h400);
      rd(8'h24, 32'h205);
      chk("us reset held", 32'h7, {29'h0, plr});
      wr(8'h00, 32'h0);
      tick(1);
      chk("us reset end", 32'h0, {28'h0, us_ur, plr});
      results();
   end
endmodule
